// [rtl/position_deviation_clear_multiplier.sv]
// Deviation counter with clear logic, reference multiplier and smoothing.
// Assumes pulse and clear pins are asynchronous; servo state, alarm,
// restart, jog and standstill come from logic on the same clock.
//
// Operation
// - Deviation count is reference pulses minus encoder feedback pulses.
// - Level-high form holds deviation zero while clear input is high.
// - Rising-edge form zeroes deviation once per rising clear transition.
// - Level-low form holds deviation zero while clear input is low.
// - Falling-edge form zeroes deviation once per falling clear transition.
// - Default automatic clear zeroes deviation during base block.
// - Automatic clear value one never clears; only clear input does.
// - Automatic clear value two clears on alarm, not on servo off.
// - Every reference pulse is scaled by the multiplier before accumulating.
// - Multiplier accepts 1 to 100, defaults 1, applies at once.
// - Select input inactive gives multiplier one, active gives setting.
// - Status output follows which multiplier is in effect.
// - Jogging or autotuning freezes the multiplier selection, not its setting.
// - Smoothing preserves the total number of reference pulses.
// - Acceleration time constant spans 0 to 65535 in 0.1 ms.
// - Moving-average time spans 0 to 10000 in 0.1 ms.
// - A zero time setting bypasses its filter; both default zero.
// - Smoothing settings written while moving apply at next standstill.
// - Deviation reads zero while a clear request is asserted.
`timescale 1ns/1ns
`default_nettype none

module position_deviation_clear_multiplier
	import posdev_pkg::*;
#(
	parameter int DEV_W = 32
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	// Register port
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [31:0] REG_RDATA_O,
	// Pulse pins
	input wire logic REF_PULSE_I,
	input wire logic REF_DIR_I,
	input wire logic FB_PULSE_I,
	input wire logic FB_DIR_I,
	input wire logic DEVIATION_CLEAR_IN_I,
	input wire logic MULT_SELECT_I,
	// Drive state
	input wire logic SERVO_ON_I,
	input wire logic ALARM_I,
	input wire logic RESTART_I,
	input wire logic JOG_TUNE_I,
	input wire logic MOTOR_STOPPED_I,
	// Status outputs
	output logic MULTIPLIER_ACTIVE_OUT_O,
	output logic [DEV_W-1:0] DEVIATION_O
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (DEV_W < 18 || DEV_W > 32) begin : g_bad_width
		$error("DEV_W must lie between 18 and 32");
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int NPIN = 6;
	localparam int P_REF = 0;
	localparam int P_RDIR = 1;
	localparam int P_FB = 2;
	localparam int P_FDIR = 3;
	localparam int P_CLR = 4;
	localparam int P_SEL = 5;

	wire logic [NPIN-1:0] pin_raw;
	wire logic [NPIN-1:0] stable_r;
	wire logic [NPIN-1:0] prev_r;

	assign pin_raw = {MULT_SELECT_I, DEVIATION_CLEAR_IN_I, FB_DIR_I,
		FB_PULSE_I, REF_DIR_I, REF_PULSE_I};

	for (genvar g = 0; g < NPIN; g++) begin : g_sync
		logic s1_r;
		logic s2_r;
		logic s3_r;
		logic stab_r;
		logic prv_r;
		// Accept a change only once the last two stages agree
		always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
			if (!RST_B_I) begin
				s1_r <= 1'b0;
				s2_r <= 1'b0;
				s3_r <= 1'b0;
				stab_r <= 1'b0;
				prv_r <= 1'b0;
			end else begin
				s1_r <= pin_raw[g];
				s2_r <= s1_r;
				s3_r <= s2_r;
				stab_r <= (s2_r == s3_r) ? s3_r : stab_r;
				prv_r <= stab_r;
			end
		end
		assign stable_r[g] = stab_r;
		assign prev_r[g] = prv_r;
	end

	// Signed step for one counted pulse edge
	function automatic logic signed [DEV_W-1:0] pulse_step(
		input logic cur,
		input logic prev,
		input logic dir,
		input logic [6:0] mag
	);
		logic signed [DEV_W-1:0] m;
		m = $signed({{(DEV_W-7){1'b0}}, mag});
		if (cur && !prev)
			pulse_step = dir ? -m : m;
		else
			pulse_step = '0;
	endfunction

	// ----------------------------------------------------------------
	// Registers written by software
	// ----------------------------------------------------------------
	logic [15:0] form_cfg_r;
	logic [6:0] mult_set_r;
	smooth_cfg_s smooth_req_r;
	smooth_cfg_s smooth_act_r;
	clear_cfg_s clr_cfg_r;

	wire logic wr_form = REG_WR_I && REG_ADDR_I == ADDR_REFERENCE_FORM_CONFIG;
	wire logic wr_mult = REG_WR_I && REG_ADDR_I == ADDR_INPUT_PULSE_MULTIPLIER;
	wire logic wr_accel = REG_WR_I && REG_ADDR_I == ADDR_ACCEL_DECEL_TIME_CONST;
	wire logic wr_avg = REG_WR_I && REG_ADDR_I == ADDR_AVERAGE_MOVE_TIME;

	wire logic [6:0] mult_wr_val = (REG_WDATA_I[31:0] < 32'(MULT_MIN)) ?
		MULT_MIN : (REG_WDATA_I[31:0] > 32'(MULT_MAX)) ?
		MULT_MAX : REG_WDATA_I[6:0];
	wire logic [15:0] accel_wr_val = REG_WDATA_I[15:0];
	wire logic [15:0] avg_wr_val = (REG_WDATA_I[31:0] > 32'(AVERAGE_MAX)) ?
		AVERAGE_MAX : REG_WDATA_I[15:0];

	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			form_cfg_r <= FORM_CONFIG_RESET;
			mult_set_r <= MULT_RESET;
			smooth_req_r <= {SMOOTH_RESET, SMOOTH_RESET};
		end else begin
			if (wr_form)
				form_cfg_r <= REG_WDATA_I[15:0];
			if (wr_mult)
				mult_set_r <= mult_wr_val;
			if (wr_accel)
				smooth_req_r.accel <= accel_wr_val;
			if (wr_avg)
				smooth_req_r.average <= avg_wr_val;
		end
	end

	// ----------------------------------------------------------------
	// Configuration latching
	// ----------------------------------------------------------------
	// clear modes taken only at restart
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			clr_cfg_r <= {CLR_LEVEL_HIGH, AUTO_BASE_BLOCK};
		else if (RESTART_I)
			clr_cfg_r <= {clear_form_e'(form_cfg_r[CLEAR_FORM_LSB +: 2]),
				auto_clear_e'(form_cfg_r[AUTO_CLEAR_LSB +: 2])};
	end

	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			smooth_act_r <= {SMOOTH_RESET, SMOOTH_RESET};
		else if (MOTOR_STOPPED_I)
			smooth_act_r <= smooth_req_r;
	end

	// ----------------------------------------------------------------
	// Clear decision
	// ----------------------------------------------------------------
	wire logic clr_now = stable_r[P_CLR];
	wire logic clr_was = prev_r[P_CLR];
	wire logic base_block = !SERVO_ON_I || ALARM_I;

	wire logic clr_high = clr_cfg_r.clear_form == CLR_LEVEL_HIGH && clr_now;
	wire logic clr_rise = clr_cfg_r.clear_form == CLR_RISING &&
		clr_now && !clr_was;
	wire logic clr_low = clr_cfg_r.clear_form == CLR_LEVEL_LOW && !clr_now;
	wire logic clr_fall = clr_cfg_r.clear_form == CLR_FALLING &&
		!clr_now && clr_was;
	wire logic auto_bb = clr_cfg_r.auto_clear == AUTO_BASE_BLOCK && base_block;
	// alarm only; value one never matches here
	wire logic auto_alm = clr_cfg_r.auto_clear == AUTO_ALARM && ALARM_I;

	wire logic clear_req = clr_high || clr_rise || clr_low || clr_fall ||
		auto_bb || auto_alm;

	// ----------------------------------------------------------------
	// Multiplier selection
	// ----------------------------------------------------------------
	logic mult_on_r;
	logic mult_on_nxt;

	// freeze during jog or tuning; select picks setting
	assign mult_on_nxt = JOG_TUNE_I ? mult_on_r : stable_r[P_SEL];

	// written setting applies on the next pulse
	wire logic [6:0] mult_use = mult_on_r ? mult_set_r : MULT_MIN;

	// status follows the multiplier in effect
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			mult_on_r <= 1'b0;
		else
			mult_on_r <= mult_on_nxt;
	end

	// ----------------------------------------------------------------
	// Reference scaling and feedback
	// ----------------------------------------------------------------
	// scale each reference pulse
	wire logic signed [DEV_W-1:0] ref_step = pulse_step(stable_r[P_REF],
		prev_r[P_REF], stable_r[P_RDIR], mult_use);
	wire logic signed [DEV_W-1:0] fb_step = pulse_step(stable_r[P_FB],
		prev_r[P_FB], stable_r[P_FDIR], MULT_MIN);

	// ----------------------------------------------------------------
	// Smoothing
	// ----------------------------------------------------------------
	// Pending reference is released over the combined filter time. Any
	// remainder is kept, so nothing is dropped, at the cost of a tail of
	// single pulses at the end of a move.
	logic [$clog2(UNIT_CYCLES)-1:0] unit_cnt_r;
	logic unit_tick_r;
	logic signed [DEV_W-1:0] pending_r;
	logic signed [DEV_W-1:0] pending_nxt;
	logic signed [DEV_W-1:0] release_amt;

	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			unit_cnt_r <= '0;
			unit_tick_r <= 1'b0;
		end else begin
			unit_tick_r <= unit_cnt_r == ($clog2(UNIT_CYCLES))'(UNIT_CYCLES - 1);
			if (unit_cnt_r == ($clog2(UNIT_CYCLES))'(UNIT_CYCLES - 1))
				unit_cnt_r <= '0;
			else
				unit_cnt_r <= unit_cnt_r + 1'b1;
		end
	end

	wire logic [16:0] filt_time = {1'b0, smooth_act_r.accel} +
		{1'b0, smooth_act_r.average};
	wire logic filt_bypass = filt_time == 17'h00000;
	wire logic signed [DEV_W-1:0] filt_quot = pending_r /
		$signed({{(DEV_W-17){1'b0}}, filt_time});
	wire logic signed [DEV_W-1:0] one_step = pending_r[DEV_W-1] ?
		-$signed(DEV_W'(1)) : $signed(DEV_W'(1));

	// release never exceeds what is pending
	always_comb begin
		release_amt = '0;
		if (filt_bypass)
			release_amt = pending_r;
		else if (unit_tick_r && pending_r != '0)
			release_amt = (filt_quot != '0) ? filt_quot : one_step;
	end

	assign pending_nxt = clear_req ? '0 : pending_r - release_amt + ref_step;

	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			pending_r <= '0;
		else
			pending_r <= pending_nxt;
	end

	// ----------------------------------------------------------------
	// Deviation counter
	// ----------------------------------------------------------------
	logic signed [DEV_W-1:0] deviation_r;
	logic signed [DEV_W-1:0] deviation_nxt;

	assign deviation_nxt = clear_req ? '0 : deviation_r + release_amt - fb_step;

	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			deviation_r <= '0;
		else
			deviation_r <= deviation_nxt;
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic clearing_r;
	logic [31:0] rdata_nxt;
	wire logic [31:0] status_word = {20'h00000,
		2'b00, clr_cfg_r.auto_clear, 2'b00, clr_cfg_r.clear_form,
		1'b0, pending_r != '0, clearing_r, mult_on_r};

	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			clearing_r <= 1'b0;
		else
			clearing_r <= clear_req;
	end

	always_comb begin
		rdata_nxt = 32'h00000000;
		case (REG_ADDR_I)
			ADDR_REFERENCE_FORM_CONFIG: rdata_nxt = {16'h0000, form_cfg_r};
			ADDR_INPUT_PULSE_MULTIPLIER: rdata_nxt = {25'h0000000, mult_set_r};
			ADDR_ACCEL_DECEL_TIME_CONST:
				rdata_nxt = {16'h0000, smooth_req_r.accel};
			ADDR_AVERAGE_MOVE_TIME: rdata_nxt = {16'h0000, smooth_req_r.average};
			ADDR_DEVIATION: rdata_nxt = 32'($signed(deviation_r));
			ADDR_STATUS: rdata_nxt = status_word;
			default: rdata_nxt = 32'h00000000;
		endcase
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			REG_RDATA_O <= 32'h00000000;
			MULTIPLIER_ACTIVE_OUT_O <= 1'b0;
			DEVIATION_O <= '0;
		end else begin
			REG_RDATA_O <= REG_RD_I ? rdata_nxt : 32'h00000000;
			MULTIPLIER_ACTIVE_OUT_O <= mult_on_r;
			DEVIATION_O <= deviation_nxt;
		end
	end

endmodule

`default_nettype wire

// [rtl/posdev_pkg.sv]
// Shared constants and types for the position deviation front end.
// Assumes a 10 MHz system clock and a word-wide register port.
package posdev_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS = 100;
	localparam int TIME_UNIT_NS = 100000;
	localparam int UNIT_CYCLES = (TIME_UNIT_NS + CLOCK_PERIOD_NS - 1) /
		CLOCK_PERIOD_NS;
	localparam int CLEAR_LEVEL_MIN_US = 250;
	localparam int CLEAR_EDGE_MIN_US = 20;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_REFERENCE_FORM_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_INPUT_PULSE_MULTIPLIER = 8'h04;
	localparam logic [7:0] ADDR_ACCEL_DECEL_TIME_CONST = 8'h08;
	localparam logic [7:0] ADDR_AVERAGE_MOVE_TIME = 8'h0C;
	localparam logic [7:0] ADDR_DEVIATION = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;

	// ----------------------------------------------------------------
	// Field layout and limits
	// ----------------------------------------------------------------
	localparam int CLEAR_FORM_LSB = 4;
	localparam int AUTO_CLEAR_LSB = 8;
	localparam int FIELD_W = 4;
	localparam logic [15:0] FORM_CONFIG_RESET = 16'h0000;
	localparam logic [6:0] MULT_MIN = 7'h01;
	localparam logic [6:0] MULT_MAX = 7'h64;
	localparam logic [6:0] MULT_RESET = 7'h01;
	localparam logic [15:0] ACCEL_MAX = 16'hFFFF;
	localparam logic [15:0] AVERAGE_MAX = 16'h2710;
	localparam logic [15:0] SMOOTH_RESET = 16'h0000;
	localparam int STAT_MULT_ACTIVE = 0;
	localparam int STAT_CLEARING = 1;
	localparam int STAT_PENDING = 2;
	localparam int STAT_FORM_LSB = 4;
	localparam int STAT_AUTO_LSB = 8;

	// ----------------------------------------------------------------
	// Modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CLR_LEVEL_HIGH, CLR_RISING, CLR_LEVEL_LOW, CLR_FALLING
	} clear_form_e;

	typedef enum logic [1:0] {
		AUTO_BASE_BLOCK, AUTO_NONE, AUTO_ALARM, AUTO_RESERVED
	} auto_clear_e;

	typedef struct packed {
		clear_form_e clear_form;
		auto_clear_e auto_clear;
	} clear_cfg_s;

	typedef struct packed {
		logic [15:0] accel;
		logic [15:0] average;
	} smooth_cfg_s;

endpackage

// [sim/position_deviation_clear_multiplier_assertions.sv]
// Checker for the deviation front end, watching the top module ports.
// Assumes the register map and field limits of posdev_pkg.
`timescale 1ns/1ns
`default_nettype none
module posdev_checker
	import posdev_pkg::*;
#(
	parameter int DEV_W = 32
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	// Register port
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [31:0] REG_RDATA_O,
	// Pins and status
	input wire logic MULT_SELECT_I,
	input wire logic JOG_TUNE_I,
	input wire logic MULTIPLIER_ACTIVE_OUT_O,
	input wire logic [DEV_W-1:0] DEVIATION_O
);
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RST_B_I);
	// Run lengths of a steady select pin; jogging restarts them
	logic [3:0] lo_r, hi_r, lo_nxt, hi_nxt;
	assign lo_nxt = (!MULT_SELECT_I && !JOG_TUNE_I) ?
		lo_r + {3'h0, lo_r != 4'hF} : 4'h0;
	assign hi_nxt = (MULT_SELECT_I && !JOG_TUNE_I) ?
		hi_r + {3'h0, hi_r != 4'hF} : 4'h0;
	always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			lo_r <= 4'h0;
			hi_r <= 4'h0;
		end else begin
			lo_r <= lo_nxt;
			hi_r <= hi_nxt;
		end
	end
	function automatic logic [31:0] mclamp(input logic [31:0] w);
		return (w == 32'h0) ? 32'h1 : (w > 32'h64) ? 32'h64 : w;
	endfunction
	property p_mult_clamp;
		REG_WR_I && REG_ADDR_I == ADDR_INPUT_PULSE_MULTIPLIER ##1
		REG_RD_I && REG_ADDR_I == ADDR_INPUT_PULSE_MULTIPLIER
		|=> REG_RDATA_O == mclamp($past(REG_WDATA_I, 2));
	endproperty
	a_mult_clamp: assert property (p_mult_clamp)
		else $error("multiplier readback not clamped");
	property p_mult_range;
		REG_RD_I && REG_ADDR_I == ADDR_INPUT_PULSE_MULTIPLIER
		|=> REG_RDATA_O inside {[32'h1:32'h64]};
	endproperty
	a_mult_range: assert property (p_mult_range)
		else $error("multiplier outside range");
	property p_accel;
		REG_WR_I && REG_ADDR_I == ADDR_ACCEL_DECEL_TIME_CONST ##1
		REG_RD_I && REG_ADDR_I == ADDR_ACCEL_DECEL_TIME_CONST
		|=> REG_RDATA_O == {16'h0, $past(REG_WDATA_I[15:0], 2)};
	endproperty
	a_accel: assert property (p_accel)
		else $error("accel time readback wrong");
	property p_avg;
		REG_WR_I && REG_ADDR_I == ADDR_AVERAGE_MOVE_TIME ##1
		REG_RD_I && REG_ADDR_I == ADDR_AVERAGE_MOVE_TIME
		|=> REG_RDATA_O[15:0] == ($past(REG_WDATA_I, 2) > 32'(AVERAGE_MAX) ?
		AVERAGE_MAX : $past(REG_WDATA_I[15:0], 2));
	endproperty
	a_avg: assert property (p_avg)
		else $error("average time readback wrong");
	property p_form;
		REG_WR_I && REG_ADDR_I == ADDR_REFERENCE_FORM_CONFIG ##1
		REG_RD_I && REG_ADDR_I == ADDR_REFERENCE_FORM_CONFIG
		|=> REG_RDATA_O == {16'h0, $past(REG_WDATA_I[15:0], 2)};
	endproperty
	a_form: assert property (p_form)
		else $error("form config readback wrong");
	property p_dev_read;
		REG_RD_I && REG_ADDR_I == ADDR_DEVIATION |=> REG_RDATA_O ==
		32'($past(DEVIATION_O));
	endproperty
	a_dev_read: assert property (p_dev_read)
		else $error("deviation register differs from output");
	property p_stat_bit;
		REG_RD_I && REG_ADDR_I == ADDR_STATUS |=> REG_RDATA_O[0] ==
		MULTIPLIER_ACTIVE_OUT_O;
	endproperty
	a_stat_bit: assert property (p_stat_bit)
		else $error("status bit differs from output");
	property p_sel_off;
		lo_r >= 4'h8 |-> !MULTIPLIER_ACTIVE_OUT_O;
	endproperty
	a_sel_off: assert property (p_sel_off)
		else $error("multiplier active with select low");
	property p_sel_on;
		hi_r >= 4'h8 |-> MULTIPLIER_ACTIVE_OUT_O;
	endproperty
	a_sel_on: assert property (p_sel_on)
		else $error("multiplier inactive with select high");
	property p_jog;
		$past(JOG_TUNE_I) && $past(JOG_TUNE_I, 2) |-> $stable(MULTIPLIER_ACTIVE_OUT_O);
	endproperty
	a_jog: assert property (p_jog)
		else $error("multiplier changed while jogging");
endmodule
`default_nettype wire

// [sim/host_pulse_model.sv]
// Pulse train source for the host reference or the encoder feedback.
// Assumes send() is entered at a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module host_pulse_model (
	// Clock
	input wire logic clock_i,
	// Pulse pins
	output var logic pulse_o,
	output var logic dir_o
);
	initial begin
		pulse_o = 1'b0;
		dir_o = 1'b0;
	end
	task automatic send(input int n, input logic d);
		dir_o <= d;
		repeat (n) begin
			repeat (4) @(posedge clock_i);
			pulse_o <= 1'b1;
			repeat (4) @(posedge clock_i);
			pulse_o <= 1'b0;
		end
		// Pin sync delay before anyone looks
		repeat (8) @(posedge clock_i);
	endtask
endmodule
`default_nettype wire

// [sim/position_deviation_clear_multiplier_tb.sv]
// Self-checking bench for the deviation front end.
// Assumes a 10 MHz clock and the register map of posdev_pkg.
`timescale 1ns/1ns
`default_nettype none
module position_deviation_clear_multiplier_tb
	import posdev_pkg::*;
;
	logic clock;
	logic rst_b = 1'b0, wr = 1'b0, rd = 1'b0, clr = 1'b0, sel = 1'b0;
	logic son = 1'b1, alm = 1'b0, rs = 1'b0, jog = 1'b0, stop = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, dev;
	logic refp, refd, fbp, fbd, mact;
	int fails = 0;
	int checks = 0;
	position_deviation_clear_multiplier #(.DEV_W(32)) u_dut (
		.CLOCK_I(clock),
		.RST_B_I(rst_b),
		.REG_ADDR_I(addr),
		.REG_WDATA_I(wdata),
		.REG_WR_I(wr),
		.REG_RD_I(rd),
		.REG_RDATA_O(rdata),
		.REF_PULSE_I(refp),
		.REF_DIR_I(refd),
		.FB_PULSE_I(fbp),
		.FB_DIR_I(fbd),
		.DEVIATION_CLEAR_IN_I(clr),
		.MULT_SELECT_I(sel),
		.SERVO_ON_I(son),
		.ALARM_I(alm),
		.RESTART_I(rs),
		.JOG_TUNE_I(jog),
		.MOTOR_STOPPED_I(stop),
		.MULTIPLIER_ACTIVE_OUT_O(mact),
		.DEVIATION_O(dev)
	);
	host_pulse_model u_ref (.clock_i(clock), .pulse_o(refp), .dir_o(refd));
	host_pulse_model u_fb (.clock_i(clock), .pulse_o(fbp), .dir_o(fbd));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// ----------------------------------------------------------------
	// Tasks, all entered at a rising edge
	// ----------------------------------------------------------------
	task automatic wrt(input logic [7:0] a, input logic [31:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rdt(input logic [7:0] a, output logic [31:0] v);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		@(posedge clock);
		v = rdata;
	endtask
	task automatic restart;
		rs <= 1'b1;
		@(posedge clock);
		rs <= 1'b0;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s exp %0h got %0h", n, e, g);
		end
	endtask
	task automatic finish_test;
		if (fails == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Whole run is near 12000 cycles
	initial begin
		repeat (40000) @(posedge clock);
		fails++;
		finish_test();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] v;
		int e;
		int f;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		rdt(ADDR_INPUT_PULSE_MULTIPLIER, v);
		chk("mult", 32'h1, v);
		rdt(ADDR_ACCEL_DECEL_TIME_CONST, v);
		chk("accel", 32'h0, v);
		rdt(ADDR_AVERAGE_MOVE_TIME, v);
		chk("average", 32'h0, v);
		rdt(8'h3C, v);
		chk("unmapped", 32'h0, v);
		wrt(ADDR_INPUT_PULSE_MULTIPLIER, 32'h5);
		u_ref.send(3, 1'b0);
		chk("dev x1", 32'h3, dev);
		sel <= 1'b1;
		for (int i = 0; i < 20 && mact !== 1'b1; i++) @(posedge clock);
		chk("mact on", 32'h1, 32'(mact));
		u_ref.send(2, 1'b0);
		chk("dev x5", 32'hD, dev);
		u_fb.send(4, 1'b0);
		chk("dev fb", 32'h9, dev);
		rdt(ADDR_DEVIATION, v);
		chk("dev reg", 32'h9, v);
		u_ref.send(1, 1'b1);
		chk("dev rev ref", 32'h4, dev);
		u_fb.send(2, 1'b1);
		chk("dev rev fb", 32'h6, dev);
		jog <= 1'b1;
		repeat (2) @(posedge clock);
		sel <= 1'b0;
		repeat (10) @(posedge clock);
		chk("jog hold", 32'h1, 32'(mact));
		jog <= 1'b0;
		repeat (10) @(posedge clock);
		chk("mact off", 32'h0, 32'(mact));
		wrt(ADDR_INPUT_PULSE_MULTIPLIER, 32'hC8);
		rdt(ADDR_INPUT_PULSE_MULTIPLIER, v);
		chk("mult max", 32'h64, v);
		wrt(ADDR_INPUT_PULSE_MULTIPLIER, 32'h0);
		rdt(ADDR_INPUT_PULSE_MULTIPLIER, v);
		chk("mult min", 32'h1, v);
		for (f = 0; f < 4; f++) begin
			clr <= f[1];
			wrt(ADDR_REFERENCE_FORM_CONFIG, (32'(f) << CLEAR_FORM_LSB) | 32'h100);
			restart();
			rdt(ADDR_STATUS, v);
			chk("form", 32'(f), (v >> STAT_FORM_LSB) & 32'h3);
			u_ref.send(2, 1'b0);
			clr <= !f[1];
			repeat (f[0] ? 200 : 2500) @(posedge clock);
			chk("cleared", 32'h0, dev);
			rdt(ADDR_STATUS, v);
			chk("clearing", 32'(!f[0]), (v >> STAT_CLEARING) & 32'h1);
			u_ref.send(1, 1'b0);
			chk("held", 32'(f[0]), dev);
			clr <= f[1];
			repeat (10) @(posedge clock);
			chk("once", 32'(f[0]), dev);
		end
		wrt(ADDR_REFERENCE_FORM_CONFIG, 32'h210);
		rdt(ADDR_REFERENCE_FORM_CONFIG, v);
		rdt(ADDR_STATUS, v);
		chk("no restart", 32'h3, (v >> STAT_FORM_LSB) & 32'h3);
		// Falling form sees the clear pin drop and zeroes the count
		clr <= 1'b0;
		repeat (10) @(posedge clock);
		e = 0;
		for (f = 0; f < 3; f++) begin
			wrt(ADDR_REFERENCE_FORM_CONFIG, 32'(f) << AUTO_CLEAR_LSB);
			restart();
			u_ref.send(2, 1'b0);
			e = e + 2;
			chk("auto", 32'(e), dev);
			son <= 1'b0;
			repeat (10) @(posedge clock);
			son <= 1'b1;
			e = (f == 0) ? 0 : e;
			chk("servo off", 32'(e), dev);
			alm <= 1'b1;
			repeat (10) @(posedge clock);
			alm <= 1'b0;
			e = (f != 1) ? 0 : e;
			chk("alarm", 32'(e), dev);
		end
		// Settings written while moving stay unused until standstill
		stop <= 1'b0;
		wrt(ADDR_AVERAGE_MOVE_TIME, 32'h4E20);
		rdt(ADDR_AVERAGE_MOVE_TIME, v);
		chk("avg max", 32'h2710, v);
		wrt(ADDR_ACCEL_DECEL_TIME_CONST, 32'hFFFF);
		rdt(ADDR_ACCEL_DECEL_TIME_CONST, v);
		chk("accel max", 32'hFFFF, v);
		u_ref.send(1, 1'b0);
		chk("deferred", 32'(e + 1), dev);
		stop <= 1'b1;
		@(posedge clock);
		u_ref.send(4, 1'b0);
		chk("spread", 32'h0, 32'(dev > 32'(e + 2)));
		rdt(ADDR_STATUS, v);
		chk("pending", 32'h1, (v >> STAT_PENDING) & 32'h1);
		// One pulse leaves per 1000-cycle tick at the longest times
		repeat (6000) @(posedge clock);
		chk("smoothed", 32'(e + 5), dev);
		finish_test();
	end
endmodule
bind position_deviation_clear_multiplier posdev_checker #(.DEV_W(DEV_W)) u_chk (
	.CLOCK_I(CLOCK_I),
	.RST_B_I(RST_B_I),
	.REG_ADDR_I(REG_ADDR_I),
	.REG_WDATA_I(REG_WDATA_I),
	.REG_WR_I(REG_WR_I),
	.REG_RD_I(REG_RD_I),
	.REG_RDATA_O(REG_RDATA_O),
	.MULT_SELECT_I(MULT_SELECT_I),
	.JOG_TUNE_I(JOG_TUNE_I),
	.MULTIPLIER_ACTIVE_OUT_O(MULTIPLIER_ACTIVE_OUT_O),
	.DEVIATION_O(DEVIATION_O)
);
`default_nettype wire
